//--- design/irq_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts of the
// interrupt control block. Included by the package and the design module.
// Summary of operation
// - Eleven request sources: pin, timer zero, port change, peripherals.
// - Global enable at bit 7 gates all unmasked requests.
// - Every reset clears the global enable.
// - Each source has its own enable bit; clear blocks it.
// - Return-from-interrupt leaves service and sets global enable.
// - Pin, port change, timer zero flags and enables sit in core register.
// - Eight peripheral flags in flag register, enables in enable register.
// - Taking interrupt clears global enable, pushes return, vectors to 0004h.
// - External events vector three or four cycles later, any instruction.
// - Flags set on event regardless of any enable.
// - Request due while global enable is cleared stays pending.
// - Interrupt wake runs next instruction, then vectors if enabled.
// - Interrupt wake needs a set flag and leaves flags untouched.
// - Status takes uuu1 0uuu on interrupt wake, uuu0 0uuu on watchdog.
// - Pin request edge triggered, direction from edge select.
// - Timer zero rollover from FFh to 00h sets its flag.
// - Port change sets flag on selected pins only.
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

`define ADDR_CORE_CTRL 4'h0
`define ADDR_PERIPH_FLAG 4'h1
`define ADDR_PERIPH_EN 4'h2
`define ADDR_PIN_SEL 4'h3
`define ADDR_OPTION 4'h4
`define ADDR_STATUS 4'h5
`define ADDR_SRC_STATUS 4'h6
`define ADDR_SRC_CLEAR 4'h7
`define ADDR_SRC_EN 4'h8

`define BIT_GIE 7
`define BIT_PEIE 6
`define BIT_T0IE 5
`define BIT_EXTE 4
`define BIT_PCE 3
`define BIT_T0F 2
`define BIT_EXTF 1
`define BIT_PCF 0
`define BIT_EDGE 6
`define BIT_TO 4
`define BIT_PD 3

`define RST_CORE_CTRL 8'h00
`define RST_PERIPH 8'h00
`define RST_PIN_SEL 8'h00
`define RST_OPTION 8'h40
`define RST_STATUS 8'h18

`define VECTOR_ADDR 13'h0004
`define SYNC_LATENCY 2'd3

`endif

//--- design/irq_ctrl_pkg.sv
// Types shared by the interrupt control block.
// Assumes irq_ctrl_regs.svh sits in the include path.
`include "irq_ctrl_regs.svh"
package irq_ctrl_pkg;
    typedef enum logic [1:0] {RUN, SLEEPING, WAKE_STEP} core_state_type;
endpackage : irq_ctrl_pkg

//--- design/irq_ctrl.sv
// Interrupt control logic of a small 8-bit controller core.
// Assumes one clock at the instruction rate and a core sequencer that
// reports instruction boundaries, sleep and return-from-interrupt.
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_regs.svh"

module irq_ctrl #(
    parameter int PORT_WIDTH = 8,
    parameter int PC_WIDTH = 13
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Avalon-MM slave
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // Event sources
    input wire logic i_ext_pin,
    input wire logic [PORT_WIDTH-1:0] i_first_io_port,
    input wire logic i_timer_zero_tick,
    input wire logic [7:0] i_timer_zero,
    input wire logic [7:0] i_periph_event,
    // Core sequencer
    input wire logic i_instr_boundary,
    input wire logic i_gie_clear_instr,
    input wire logic i_return_from_irq_instr,
    input wire logic i_sleep_instr,
    input wire logic i_watchdog_timeout,
    input wire logic [PC_WIDTH-1:0] i_program_counter,
    output logic o_take_irq,
    output logic [PC_WIDTH-1:0] o_vector,
    output logic o_push_req,
    output logic [PC_WIDTH-1:0] o_push_addr,
    output logic o_wake,
    output logic o_sleeping,
    output logic o_irq
);
    initial begin
        if (PORT_WIDTH < 1 || PORT_WIDTH > 8) $error("PORT_WIDTH must be 1..8");
        if (PC_WIDTH < 4) $error("PC_WIDTH must be at least 4");
    end

    logic [7:0] core_ctrl;
    logic [7:0] periph_flag_reg;
    logic [7:0] periph_enable_reg;
    logic [7:0] pin_change_select_reg;
    logic [7:0] option_reg;
    logic [7:0] status_reg;
    logic [2:0] src_status;
    logic [2:0] src_enable;
    irq_ctrl_pkg::core_state_type state;
    logic [1:0] latency_cnt;

    // Two-stage synchronisers for pins
    logic ext_meta, ext_sync, ext_last;
    logic [PORT_WIDTH-1:0] port_meta, port_sync, port_last;
    always_ff @(posedge i_sys_clk) begin
        ext_meta <= i_ext_pin;
        ext_sync <= ext_meta;
        ext_last <= ext_sync;
        port_meta <= i_first_io_port;
        port_sync <= port_meta;
        port_last <= port_sync;
    end

    logic ext_edge, port_change, t0_ovf;
    logic [PORT_WIDTH-1:0] sel_bits;
    assign sel_bits = pin_change_select_reg[PORT_WIDTH-1:0];
    assign ext_edge = option_reg[`BIT_EDGE] ? (ext_sync & ~ext_last)
                                           : (~ext_sync & ext_last);
    assign port_change = |((port_sync ^ port_last) & sel_bits);
    assign t0_ovf = i_timer_zero_tick && (i_timer_zero == 8'hff);

    logic wr_core, wr_pflag, bus_acc;
    assign bus_acc = (i_read | i_write) & o_waitrequest;
    assign wr_core = i_write && !o_waitrequest && i_address == `ADDR_CORE_CTRL;
    assign wr_pflag = i_write && !o_waitrequest && i_address == `ADDR_PERIPH_FLAG;

    logic core_pending, periph_pending, irq_pending, take_now;
    assign periph_pending = core_ctrl[`BIT_PEIE]
        && |(periph_flag_reg & periph_enable_reg);
    assign core_pending = (core_ctrl[`BIT_T0IE] & core_ctrl[`BIT_T0F])
        | (core_ctrl[`BIT_EXTE] & core_ctrl[`BIT_EXTF])
        | (core_ctrl[`BIT_PCE] & core_ctrl[`BIT_PCF]);
    assign irq_pending = core_pending | periph_pending;
    // A clearing instruction in flight blocks the take; request stays pending
    assign take_now = core_ctrl[`BIT_GIE] && irq_pending && !i_gie_clear_instr
        && i_instr_boundary && latency_cnt == 2'd0
        && state == irq_ctrl_pkg::RUN;

    // Latency counter: pending request waits a fixed number of cycles
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || !irq_pending || !core_ctrl[`BIT_GIE]) begin
            latency_cnt <= `SYNC_LATENCY - 2'd1;
        end else if (latency_cnt != 2'd0) begin
            latency_cnt <= latency_cnt - 2'd1;
        end
    end

    // Core control: flags set on events, set wins over software clear
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            core_ctrl <= `RST_CORE_CTRL;
        end else begin
            if (wr_core) begin
                core_ctrl <= i_writedata[7:0];
            end
            if (take_now) begin
                core_ctrl[`BIT_GIE] <= 1'b0;
            end else if (i_return_from_irq_instr) begin
                core_ctrl[`BIT_GIE] <= 1'b1;
            end else if (i_gie_clear_instr) begin
                core_ctrl[`BIT_GIE] <= 1'b0;
            end
            if (ext_edge) core_ctrl[`BIT_EXTF] <= 1'b1;
            if (t0_ovf) core_ctrl[`BIT_T0F] <= 1'b1;
            if (port_change) core_ctrl[`BIT_PCF] <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            periph_flag_reg <= `RST_PERIPH;
        end else begin
            periph_flag_reg <= (wr_pflag ? i_writedata[7:0] : periph_flag_reg)
                | i_periph_event;
        end
    end

    // Sleep and wake sequencing
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state <= irq_ctrl_pkg::RUN;
            o_wake <= 1'b0;
            o_sleeping <= 1'b0;
            status_reg <= `RST_STATUS;
        end else begin
            o_wake <= 1'b0;
            unique case (state)
                irq_ctrl_pkg::RUN: begin
                    if (i_sleep_instr) begin
                        state <= irq_ctrl_pkg::SLEEPING;
                        o_sleeping <= 1'b1;
                        status_reg[`BIT_PD] <= 1'b0;
                        status_reg[`BIT_TO] <= 1'b1;
                    end
                end
                irq_ctrl_pkg::SLEEPING: begin
                    if (irq_pending) begin
                        // Flags left set; core then runs PC+1 before vectoring
                        state <= irq_ctrl_pkg::WAKE_STEP;
                        o_wake <= 1'b1;
                        o_sleeping <= 1'b0;
                        status_reg[`BIT_TO] <= 1'b1;
                        status_reg[`BIT_PD] <= 1'b0;
                    end else if (i_watchdog_timeout) begin
                        state <= irq_ctrl_pkg::RUN;
                        o_wake <= 1'b1;
                        o_sleeping <= 1'b0;
                        status_reg[`BIT_TO] <= 1'b0;
                        status_reg[`BIT_PD] <= 1'b0;
                    end
                end
                irq_ctrl_pkg::WAKE_STEP: begin
                    if (i_instr_boundary) begin
                        state <= irq_ctrl_pkg::RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_take_irq <= 1'b0;
            o_push_req <= 1'b0;
            o_push_addr <= '0;
            o_vector <= PC_WIDTH'(`VECTOR_ADDR);
        end else begin
            o_take_irq <= take_now;
            o_push_req <= take_now;
            o_vector <= PC_WIDTH'(`VECTOR_ADDR);
            if (take_now) begin
                o_push_addr <= i_program_counter;
            end
        end
    end

    // Event summary with sticky status, enable and write-one-to-clear
    logic [2:0] src_events;
    assign src_events = {take_now, o_wake, irq_pending & ~core_ctrl[`BIT_GIE]};
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            src_status <= 3'h0;
            src_enable <= 3'h0;
            o_irq <= 1'b0;
        end else begin
            src_status <= (src_status & ~((i_write && !o_waitrequest
                && i_address == `ADDR_SRC_CLEAR) ? i_writedata[2:0] : 3'h0))
                | src_events;
            if (i_write && !o_waitrequest && i_address == `ADDR_SRC_EN) begin
                src_enable <= i_writedata[2:0];
            end
            o_irq <= |(src_status & src_enable);
        end
    end

    // Bus slave: one wait cycle, then answer
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h0;
            periph_enable_reg <= `RST_PERIPH;
            pin_change_select_reg <= `RST_PIN_SEL;
            option_reg <= `RST_OPTION;
        end else begin
            o_waitrequest <= !bus_acc;
            if (i_write && !o_waitrequest) begin
                unique case (i_address)
                    `ADDR_PERIPH_EN: periph_enable_reg <= i_writedata[7:0];
                    `ADDR_PIN_SEL: pin_change_select_reg <= i_writedata[7:0];
                    `ADDR_OPTION: option_reg <= i_writedata[7:0];
                    default: ;
                endcase
            end
            if (bus_acc && i_read) begin
                unique case (i_address)
                    `ADDR_CORE_CTRL: o_readdata <= {24'h0, core_ctrl};
                    `ADDR_PERIPH_FLAG: o_readdata <= {24'h0, periph_flag_reg};
                    `ADDR_PERIPH_EN: o_readdata <= {24'h0, periph_enable_reg};
                    `ADDR_PIN_SEL: o_readdata <= {24'h0, pin_change_select_reg};
                    `ADDR_OPTION: o_readdata <= {24'h0, option_reg};
                    `ADDR_STATUS: o_readdata <= {24'h0, status_reg};
                    `ADDR_SRC_STATUS: o_readdata <= {29'h0, src_status};
                    `ADDR_SRC_EN: o_readdata <= {29'h0, src_enable};
                    default: o_readdata <= 32'h0;
                endcase
            end
        end
    end

    reset_gie_a: assert property (@(posedge i_sys_clk)
        i_srst |=> !core_ctrl[`BIT_GIE]) else $error("reset left enable set");
    take_clears_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        take_now |=> !core_ctrl[`BIT_GIE] && o_take_irq && o_push_req)
        else $error("take did not clear enable");
    vector_fixed_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_take_irq |-> o_vector == `VECTOR_ADDR) else $error("bad vector");
    no_take_off_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        !core_ctrl[`BIT_GIE] |=> !o_take_irq) else $error("take while disabled");
    clear_blocks_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_gie_clear_instr |=> !o_take_irq) else $error("take during clear");
    return_from_irq_instr_sets_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_return_from_irq_instr && !take_now |=> core_ctrl[`BIT_GIE])
        else $error("return did not enable");
    ext_flag_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        ext_edge |=> core_ctrl[`BIT_EXTF]) else $error("pin flag missed");
    t0_flag_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        t0_ovf |=> core_ctrl[`BIT_T0F]) else $error("timer flag missed");
    periph_flag_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        |i_periph_event |=> |periph_flag_reg) else $error("periph flag missed");
    wake_status_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        state == irq_ctrl_pkg::SLEEPING && irq_pending
        |=> status_reg[`BIT_TO] && !status_reg[`BIT_PD] && o_wake)
        else $error("bad wake status");
    masked_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_take_irq |-> $past(irq_pending)) else $error("take without request");

    // Port flag, return address, latency, enable clear, sleep and wake checks
    port_flag_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        port_change |=> core_ctrl[`BIT_PCF])
        else $error("port flag missed");
    push_addr_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        take_now |=> o_push_addr == $past(i_program_counter))
        else $error("wrong return address");
    latency_min_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        take_now |-> $past(irq_pending, 1) && $past(irq_pending, 2)
        && $past(core_ctrl[`BIT_GIE], 1) && $past(core_ctrl[`BIT_GIE], 2))
        else $error("take before latency");
    clear_gie_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_gie_clear_instr && !i_return_from_irq_instr |=> !core_ctrl[`BIT_GIE])
        else $error("clear left enable set");
    sleep_entry_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        state == irq_ctrl_pkg::RUN && i_sleep_instr |=> o_sleeping && !status_reg[`BIT_PD])
        else $error("sleep not entered");
    sleep_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        state == irq_ctrl_pkg::SLEEPING && !irq_pending && !i_watchdog_timeout |=> o_sleeping)
        else $error("left sleep without cause");
    wdt_status_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        state == irq_ctrl_pkg::SLEEPING && !irq_pending && i_watchdog_timeout
        |=> !status_reg[`BIT_TO] && !status_reg[`BIT_PD] && o_wake) else $error("bad wdt status");
    wake_keeps_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        state == irq_ctrl_pkg::SLEEPING && irq_pending && !(i_write && !o_waitrequest)
        |=> irq_pending) else $error("wake flag lost");
    wake_no_take_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_wake |-> !o_take_irq ##1 !o_take_irq)
        else $error("vector before next instruction");

endmodule : irq_ctrl
`default_nettype wire

//--- bench/core_seq_model.sv
// Behavioural model of the core instruction sequencer on the far side.
// Assumes the take pulse comes from the interrupt control block.
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_regs.svh"

module core_seq_model (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_take_irq,
    output logic o_instr_boundary,
    output logic [12:0] o_program_counter
);
    // Random stalls, one cycle in four on average, mimic instructions of one or more cycles
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_instr_boundary <= 1'b0;
        end else begin
            o_instr_boundary <= ($urandom % 4) != 0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_program_counter <= 13'h0000;
        end else if (i_take_irq) begin
            o_program_counter <= `VECTOR_ADDR;
        end else if (o_instr_boundary) begin
            o_program_counter <= o_program_counter + 13'h0001;
        end
    end
endmodule : core_seq_model
`default_nettype wire

//--- bench/mcu_interrupt_control_tb.sv
// Self-checking bench for the interrupt control block.
// Assumes the design sources and irq_ctrl_regs.svh are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_regs.svh"

module mcu_interrupt_control_tb;
    logic i_sys_clk = 1'b0, i_srst = 1'b1, i_read = 1'b0, i_write = 1'b0;
    logic [3:0] i_address = 4'h0;
    logic [31:0] i_writedata = 32'h0, o_readdata;
    logic o_waitrequest, i_ext_pin = 1'b0, i_tick = 1'b0, i_ret = 1'b0;
    logic [7:0] i_tmr = 8'h00, i_pev = 8'h00;
    logic bnd, o_take_irq, o_push_req, o_wake, o_sleeping, o_irq;
    logic [12:0] pc, o_vector, o_push_addr;
    logic [7:0] exp_rd[$];
    logic [12:0] exp_take[$];
    int error_cnt = 0, checks_done = 0, takes = 0;
    logic [7:0] m;
    logic [7:0] i_port = 8'h00;
    logic i_clr = 1'b0, i_slp = 1'b0, i_wdt = 1'b0;
    logic [12:0] pc_prev;
    int wakes = 0;

    always #12.5 i_sys_clk = ~i_sys_clk;

    irq_ctrl u_dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_ext_pin(i_ext_pin),
        .i_first_io_port(i_port), .i_timer_zero_tick(i_tick), .i_timer_zero(i_tmr),
        .i_periph_event(i_pev), .i_instr_boundary(bnd), .i_gie_clear_instr(i_clr),
        .i_return_from_irq_instr(i_ret), .i_sleep_instr(i_slp),
        .i_watchdog_timeout(i_wdt), .i_program_counter(pc), .o_take_irq(o_take_irq),
        .o_vector(o_vector), .o_push_req(o_push_req), .o_push_addr(o_push_addr),
        .o_wake(o_wake), .o_sleeping(o_sleeping), .o_irq(o_irq));

    core_seq_model u_core (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .i_take_irq(o_take_irq), .o_instr_boundary(bnd), .o_program_counter(pc));

    task automatic fail(input string msg);
        error_cnt++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : fail

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) fail($sformatf("data %h expected %h", got, exp));
    endtask : cmp8

    task automatic cmp13(input logic [12:0] got, input logic [12:0] exp);
        checks_done++;
        if (got !== exp) fail($sformatf("vector %h expected %h", got, exp));
    endtask : cmp13

    task automatic cmp1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
    endtask : cmp1

    task automatic give_verdict();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // One Avalon transfer held until waitrequest is seen low
    task automatic bus(input logic [3:0] a, input logic wr, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        i_address <= a;
        i_write <= wr;
        i_read <= !wr;
        i_writedata <= {24'h0, d};
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            fail("bus hang");
            give_verdict();
        end
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        exp_rd.push_back(exp);
        bus(a, 1'b0, 8'h00);
    endtask : rd

    task automatic wait_take(input int want);
        int n;
        for (n = 0; n < 60 && takes < want; n++) @(posedge i_sys_clk);
        if (takes < want) begin
            fail("no take");
            give_verdict();
        end
    endtask : wait_take

    always @(posedge i_sys_clk) begin
        pc_prev <= pc;
        if (o_wake === 1'b1) wakes++;
        if (i_read && o_waitrequest === 1'b0) begin
            cmp8(o_readdata[7:0], exp_rd.pop_front());
        end
        if (o_take_irq === 1'b1) begin
            takes++;
            if (exp_take.size() == 0) fail("unexpected take");
            else cmp13(o_vector, exp_take.pop_front());
            cmp1(o_push_req, 1'b1);
            cmp13(o_push_addr, pc_prev);
        end
    end

    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fail("timeout");
        give_verdict();
    end

    initial begin
        void'($urandom(32'h6d639f92));
        repeat (4) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        rd(`ADDR_CORE_CTRL, `RST_CORE_CTRL);
        rd(`ADDR_STATUS, `RST_STATUS);
        rd(`ADDR_OPTION, `RST_OPTION);
        rd(4'hf, 8'h00);
        m = 8'h01 << ($urandom % 8);
        @(posedge i_sys_clk) i_pev <= m;
        @(posedge i_sys_clk) i_pev <= 8'h00;
        rd(`ADDR_PERIPH_FLAG, m);
        bus(`ADDR_SRC_EN, 1'b1, 8'h04);
        bus(`ADDR_CORE_CTRL, 1'b1, 8'hc0);
        repeat (10) @(posedge i_sys_clk);
        cmp1(o_irq, 1'b0);
        exp_take.push_back(`VECTOR_ADDR);
        bus(`ADDR_PERIPH_EN, 1'b1, m);
        wait_take(1);
        rd(`ADDR_CORE_CTRL, 8'h40);
        cmp1(o_irq, 1'b1);
        bus(`ADDR_SRC_CLEAR, 1'b1, 8'h04);
        repeat (2) @(posedge i_sys_clk);
        cmp1(o_irq, 1'b0);
        bus(`ADDR_PERIPH_FLAG, 1'b1, 8'h00);
        @(posedge i_sys_clk) i_ret <= 1'b1;
        @(posedge i_sys_clk) i_ret <= 1'b0;
        rd(`ADDR_CORE_CTRL, 8'hc0);
        exp_take.push_back(`VECTOR_ADDR);
        bus(`ADDR_CORE_CTRL, 1'b1, 8'hd0);
        @(posedge i_sys_clk) i_ext_pin <= 1'b1;
        wait_take(2);
        rd(`ADDR_CORE_CTRL, 8'h52);
        bus(`ADDR_CORE_CTRL, 1'b1, 8'h50);
        i_tmr <= 8'hff;
        @(posedge i_sys_clk) i_tick <= 1'b1;
        @(posedge i_sys_clk) i_tick <= 1'b0;
        rd(`ADDR_CORE_CTRL, 8'h54);
        bus(`ADDR_OPTION, 1'b1, 8'h00);
        bus(`ADDR_PIN_SEL, 1'b1, 8'h01);
        bus(`ADDR_CORE_CTRL, 1'b1, 8'h00);
        i_ext_pin <= 1'b0;
        i_port <= 8'h02;
        repeat (4) @(posedge i_sys_clk);
        rd(`ADDR_CORE_CTRL, 8'h02);
        i_port <= 8'h03;
        repeat (4) @(posedge i_sys_clk);
        rd(`ADDR_CORE_CTRL, 8'h03);
        bus(`ADDR_CORE_CTRL, 1'b1, 8'h89);
        repeat (2) @(posedge i_sys_clk);
        i_clr <= 1'b1;
        @(posedge i_sys_clk) i_clr <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
        rd(`ADDR_CORE_CTRL, 8'h09);
        exp_take.push_back(`VECTOR_ADDR);
        @(posedge i_sys_clk) i_ret <= 1'b1;
        @(posedge i_sys_clk) i_ret <= 1'b0;
        wait_take(3);
        bus(`ADDR_CORE_CTRL, 1'b1, 8'h08);
        @(posedge i_sys_clk) i_slp <= 1'b1;
        @(posedge i_sys_clk) i_slp <= 1'b0;
        @(posedge i_sys_clk);
        cmp1(o_sleeping, 1'b1);
        rd(`ADDR_STATUS, 8'h10);
        @(posedge i_sys_clk) i_wdt <= 1'b1;
        @(posedge i_sys_clk) i_wdt <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        cmp1(o_sleeping, 1'b0);
        cmp8(wakes[7:0], 8'h01);
        rd(`ADDR_STATUS, 8'h00);
        bus(`ADDR_CORE_CTRL, 1'b1, 8'h88);
        exp_take.push_back(`VECTOR_ADDR);
        @(posedge i_sys_clk) i_slp <= 1'b1;
        @(posedge i_sys_clk) i_slp <= 1'b0;
        i_port <= 8'h02;
        wait_take(4);
        cmp8(wakes[7:0], 8'h02);
        rd(`ADDR_CORE_CTRL, 8'h09);
        rd(`ADDR_STATUS, 8'h10);
        repeat (10) @(posedge i_sys_clk);
        give_verdict();
    end
endmodule : mcu_interrupt_control_tb
`default_nettype wire
